// file: hw/svm_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module svm_ctrl
  import svm_pkg::*;
#(
  parameter int PRE_WIDTH = SVM_PRE_WIDTH
) (
  input wire logic hclk, // System clock, 16 MHz
  input wire logic hresetn, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  input wire logic cmp_below_fall, // Supply at or below 3.7 V
  input wire logic cmp_above_rise, // Supply at or above 4.0 V
  input wire logic cmp_below_rst_lo, // Supply at or below 2.3 V
  input wire logic cmp_below_rst_hi, // Supply at or below 3.6 V
  output logic external_interrupt_line_zero, // Shared monitor interrupt
  output logic undervoltage_reset, // Internal reset request
  output logic [PRE_WIDTH-1:0] free_prescaler // Prescaler value
);

  // Comparator synchronisers
  svm_cmp_s cmp_raw, sync1_reg, sync2_reg;
  assign cmp_raw = '{cmp_below_fall, cmp_above_rise, cmp_below_rst_lo,
                     cmp_below_rst_hi};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= cmp_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Bus address phase capture
  svm_aphase_s ap_reg, ap_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [1:0] ien_reg, ien_next;
  logic [1:0] stat_reg, stat_next;
  logic [PRE_WIDTH-1:0] pre_reg, pre_next;
  svm_state_e state_reg, state_next;
  logic rst_reg, rst_next;
  logic irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;

  logic det_en, thr_sel, rst_en, fall_ie, rise_ie;
  logic fall_evt, rise_evt, at_rst_level;
  logic wr_ctrl, wr_clr, wr_ien;
  logic [1:0] clr_mask;

  assign det_en = ctrl_reg[SVM_DET_EN_BIT];
  assign thr_sel = ctrl_reg[SVM_THR_SEL_BIT];
  assign rst_en = ctrl_reg[SVM_RST_EN_BIT];
  assign fall_ie = ctrl_reg[SVM_FALL_IE_BIT];
  assign rise_ie = ctrl_reg[SVM_RISE_IE_BIT];

  assign wr_ctrl = ap_reg.sel && ap_reg.write && ap_reg.addr == SVM_CTRL_OFF;
  assign wr_clr = ap_reg.sel && ap_reg.write && ap_reg.addr == SVM_CLR_OFF;
  assign wr_ien = ap_reg.sel && ap_reg.write && ap_reg.addr == SVM_IEN_OFF;
  assign clr_mask = wr_clr ? hwdata[1:0] : 2'h0;

  // Reset level per threshold select
  assign at_rst_level = thr_sel ? sync2_reg.below_rst_hi
                                : sync2_reg.below_rst_lo;

  // Detector sequence
  always_comb begin
    state_next = state_reg;
    fall_evt = 1'b0;
    rise_evt = 1'b0;
    case (state_reg)
      SVM_IDLE: begin
        if (det_en) begin
          state_next = SVM_NORMAL;
        end
      end
      SVM_NORMAL: begin
        if (sync2_reg.below_fall) begin
          fall_evt = 1'b1;
          state_next = SVM_FALLEN;
        end
      end
      SVM_FALLEN: begin
        if (at_rst_level) begin
          state_next = SVM_SPENT;
        end else if (sync2_reg.above_rise) begin
          rise_evt = 1'b1;
          state_next = SVM_NORMAL;
        end
      end
      SVM_SPENT: begin
        if (sync2_reg.above_rise) begin
          state_next = SVM_NORMAL;
        end
      end
      default: state_next = SVM_IDLE;
    endcase
    if (!det_en) begin
      state_next = SVM_IDLE;
      fall_evt = 1'b0;
      rise_evt = 1'b0;
    end
  end

  // Control and interrupt enable registers
  always_comb begin
    ctrl_next = ctrl_reg;
    ien_next = ien_reg;
    if (wr_ctrl) begin
      ctrl_next = hwdata[7:0];
    end
    if (wr_ien) begin
      ien_next = hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= SVM_CTRL_RESET;
      ien_reg <= SVM_IEN_RESET;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      ien_reg <= ien_next;
    end
  end

  // Sticky flags, set wins over a clear in the same cycle
  always_comb begin
    stat_next = stat_reg & ~clr_mask;
    if (fall_evt) begin
      stat_next[SVM_FALL_FLAG_BIT] = 1'b1;
    end
    if (rise_evt && rise_ie) begin
      stat_next[SVM_RISE_FLAG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_reg <= 2'h0;
      state_reg <= SVM_IDLE;
    end else if (clk_en) begin
      stat_reg <= stat_next;
      state_reg <= state_next;
    end
  end

  // Free-running prescaler on the system clock
  always_comb begin
    pre_next = pre_reg + 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg <= '0;
    end else if (clk_en) begin
      pre_reg <= pre_next;
    end
  end

  // Reset and interrupt outputs
  always_comb begin
    rst_next = det_en && rst_en && at_rst_level;
    irq_next = det_en && |(stat_next & ien_next &
               {fall_ie, rise_ie});
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      rst_reg <= rst_next;
      irq_reg <= irq_next;
    end
  end

  // Bus address phase and read data
  always_comb begin
    ap_next = ap_reg;
    if (hready) begin
      ap_next.sel = hsel && htrans[1];
      ap_next.write = hwrite;
      ap_next.addr = haddr[11:0];
    end
    rdata_next = 32'h0;
    if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[11:0] == SVM_CTRL_OFF) begin
        rdata_next = {24'h0, ctrl_next};
      end else if (haddr[11:0] == SVM_STAT_OFF) begin
        rdata_next = {30'h0, stat_next};
      end else if (haddr[11:0] == SVM_IEN_OFF) begin
        rdata_next = {30'h0, ien_next};
      end else if (haddr[11:0] == SVM_PRE_OFF) begin
        rdata_next = {{(32-PRE_WIDTH){1'b0}}, pre_next};
      end else begin
        rdata_next = 32'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_reg <= '0;
      rdata_reg <= 32'h0;
    end else if (clk_en) begin
      ap_reg <= ap_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign external_interrupt_line_zero = irq_reg;
  assign undervoltage_reset = rst_reg;
  assign free_prescaler = pre_reg;

  // Checks
  a_idle_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !det_en |=> !undervoltage_reset)
    else $error("reset raised with detector off");
  a_sel_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && rst_en && !thr_sel && sync2_reg.below_rst_lo
    |=> undervoltage_reset)
    else $error("low reset level ignored");
  a_rst_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !rst_en |=> !undervoltage_reset)
    else $error("reset without gate");
  a_fall_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && fall_evt |=> stat_reg[SVM_FALL_FLAG_BIT])
    else $error("fall flag not set");
  a_fall_state: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && state_reg == SVM_NORMAL && sync2_reg.below_fall
    |-> fall_evt)
    else $error("fall missed");
  a_rise_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !rise_ie && !stat_reg[0] && !wr_ctrl
    |=> !stat_reg[SVM_RISE_FLAG_BIT])
    else $error("rise flag without enable");
  a_rise_seq: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && rise_evt |=> state_reg == SVM_NORMAL)
    else $error("rise did not rearm detector");
  a_pre_step: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en |=> pre_reg == $past(pre_reg) + 1'b1)
    else $error("prescaler not counting");
  a_irq_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && fall_ie && ien_reg[1] && stat_reg[1] && !wr_clr
    && !wr_ctrl && !wr_ien |=> external_interrupt_line_zero)
    else $error("interrupt dropped");
  a_irq_off: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !det_en |=> !external_interrupt_line_zero)
    else $error("interrupt with detector off");
  a_fall_irq_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !fall_ie && stat_reg == 2'b10 && !(rise_evt && rise_ie)
    |=> !external_interrupt_line_zero)
    else $error("fall interrupt while disabled");
  a_rise_irq_gate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !rise_ie && stat_reg == 2'b01 && !fall_evt
    |=> !external_interrupt_line_zero)
    else $error("rise interrupt while disabled");
  a_irq_set: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && rise_ie && ien_reg[0] && stat_reg[0] && !wr_clr
    && !wr_ctrl && !wr_ien |=> external_interrupt_line_zero)
    else $error("rise interrupt missing");
  a_rise_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && rise_evt && rise_ie |=> stat_reg[SVM_RISE_FLAG_BIT])
    else $error("rise flag not set");
  a_fall_sticky: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && stat_reg[SVM_FALL_FLAG_BIT] && !wr_clr
    |=> stat_reg[SVM_FALL_FLAG_BIT])
    else $error("fall flag lost");
  a_fall_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_clr && hwdata[SVM_FALL_FLAG_BIT] && !fall_evt
    |=> !stat_reg[SVM_FALL_FLAG_BIT])
    else $error("fall flag not cleared");
  a_rise_clear: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && wr_clr && hwdata[SVM_RISE_FLAG_BIT] && !rise_evt
    |=> !stat_reg[SVM_RISE_FLAG_BIT])
    else $error("rise flag not cleared");
  a_rst_follow: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && rst_en && at_rst_level |=> undervoltage_reset)
    else $error("reset level ignored");
  a_hi_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && rst_en && thr_sel && sync2_reg.below_rst_hi
    |=> undervoltage_reset)
    else $error("high reset level ignored");
  a_rst_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !at_rst_level |=> !undervoltage_reset)
    else $error("reset above reset level");
  a_freeze_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(pre_reg) && $stable(stat_reg)
    && $stable(ctrl_reg) && $stable(state_reg))
    else $error("state moved while frozen");
  a_det_idle: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && !det_en |=> state_reg == SVM_IDLE)
    else $error("detector not idle when off");
  a_spent_entry: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && det_en && state_reg == SVM_FALLEN && at_rst_level
    |=> state_reg == SVM_SPENT)
    else $error("reset level not remembered");
  a_spent_quiet: assert property (
    @(posedge hclk) disable iff (!hresetn)
    clk_en && state_reg == SVM_SPENT |-> !rise_evt)
    else $error("rise after reset level");
endmodule : svm_ctrl
`default_nettype wire

// file: inc/svm_pkg.sv
package svm_pkg;
  // Register byte offsets
  localparam logic [11:0] SVM_CTRL_OFF = 12'h000;
  localparam logic [11:0] SVM_STAT_OFF = 12'h004;
  localparam logic [11:0] SVM_CLR_OFF = 12'h008;
  localparam logic [11:0] SVM_IEN_OFF = 12'h00c;
  localparam logic [11:0] SVM_PRE_OFF = 12'h010;
  // Control field positions
  localparam int SVM_DET_EN_BIT = 7;
  localparam int SVM_THR_SEL_BIT = 3;
  localparam int SVM_RST_EN_BIT = 2;
  localparam int SVM_FALL_IE_BIT = 1;
  localparam int SVM_RISE_IE_BIT = 0;
  // Status field positions
  localparam int SVM_FALL_FLAG_BIT = 1;
  localparam int SVM_RISE_FLAG_BIT = 0;
  localparam logic [7:0] SVM_CTRL_RESET = 8'h00;
  localparam logic [1:0] SVM_IEN_RESET = 2'h3;
  localparam int SVM_PRE_WIDTH = 13;
  localparam int SVM_CLK_MHZ = 16;
  // Comparator levels, millivolts
  localparam int SVM_FALL_MV = 3700;
  localparam int SVM_RISE_MV = 4000;
  localparam int SVM_RST_LO_MV = 2300;
  localparam int SVM_RST_HI_MV = 3600;

  typedef enum logic [1:0] {
    SVM_IDLE = 2'b00,
    SVM_NORMAL = 2'b01,
    SVM_FALLEN = 2'b11,
    SVM_SPENT = 2'b10
  } svm_state_e;

  typedef struct packed {
    logic below_fall;
    logic above_rise;
    logic below_rst_lo;
    logic below_rst_hi;
  } svm_cmp_s;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic sel;
  } svm_aphase_s;
endpackage : svm_pkg

// file: testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import svm_pkg::*;
;
  localparam int PW = 4;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic ce = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] cmp = 4'h4; // Fall, rise, reset low, reset high
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic uvr;
  logic [PW-1:0] pre;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;

  svm_ctrl #(.PRE_WIDTH(PW)) dut (
    .hclk(hclk), .hresetn(hresetn), .clk_en(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .cmp_below_fall(cmp[3]), .cmp_above_rise(cmp[2]),
    .cmp_below_rst_lo(cmp[1]), .cmp_below_rst_hi(cmp[0]),
    .external_interrupt_line_zero(irq), .undervoltage_reset(uvr),
    .free_prescaler(pre)
  );

  initial begin
    forever #5 hclk = ~hclk;
  end

  task end_sim;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy

  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc

  task setc(input logic [3:0] v);
    cmp <= v;
    cyc(8);
  endtask : setc

  task t_regs;
    logic [PW-1:0] p;
    bus(1'b0, SVM_CTRL_OFF, 32'h0);
    chk(rd, {24'h0, SVM_CTRL_RESET});
    bus(1'b0, SVM_IEN_OFF, 32'h0);
    chk(rd, {30'h0, SVM_IEN_RESET});
    bus(1'b1, 12'h020, 32'hff);
    bus(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, SVM_CTRL_OFF, 32'h8f);
    bus(1'b0, SVM_CTRL_OFF, 32'h0);
    chk(rd, 32'h8f);
    bus(1'b1, SVM_CTRL_OFF, 32'h0);
    p = pre + 4'h3;
    cyc(3);
    chk(pre, p);
    cyc(16);
    chk(pre, p);
  endtask : t_regs

  task t_freeze;
    logic [PW-1:0] p;
    ce <= 1'b0;
    p = pre + 4'h1;
    cyc(5);
    chk(pre, p);
    ce <= 1'b1;
  endtask : t_freeze

  task t_off;
    bus(1'b1, SVM_CTRL_OFF, 32'h07);
    setc(4'b1011);
    chk(irq, 0);
    chk(uvr, 0);
    bus(1'b0, SVM_STAT_OFF, 32'h0);
    chk(rd, 32'h0);
    setc(4'b0100);
  endtask : t_off

  task t_fall;
    bus(1'b1, SVM_CTRL_OFF, 32'h86);
    setc(4'b1000);
    bus(1'b0, SVM_STAT_OFF, 32'h0);
    chk(rd, 32'h2);
    chk(irq, 1);
    chk(uvr, 0);
    setc(4'b0100);
    bus(1'b0, SVM_STAT_OFF, 32'h0);
    chk(rd, 32'h2);
    bus(1'b1, SVM_CLR_OFF, 32'h2);
    cyc(2);
    chk(irq, 0);
  endtask : t_fall

  task t_rise;
    bus(1'b1, SVM_CTRL_OFF, 32'h81);
    setc(4'b1000);
    chk(irq, 0);
    setc(4'b0100);
    bus(1'b0, SVM_STAT_OFF, 32'h0);
    chk(rd, 32'h3);
    chk(irq, 1);
    bus(1'b1, SVM_CLR_OFF, 32'h3);
    cyc(2);
    chk(irq, 0);
  endtask : t_rise

  task t_rst;
    bus(1'b1, SVM_CTRL_OFF, 32'h84);
    setc(4'b1001);
    chk(uvr, 0);
    setc(4'b1011);
    chk(uvr, 1);
    bus(1'b1, SVM_CTRL_OFF, 32'h80);
    cyc(4);
    chk(uvr, 0);
    bus(1'b1, SVM_CTRL_OFF, 32'h8c);
    setc(4'b1001);
    chk(uvr, 1);
    bus(1'b1, SVM_CTRL_OFF, 32'h81);
    setc(4'b0100);
    bus(1'b0, SVM_STAT_OFF, 32'h0);
    chk(rd, 32'h2);
  endtask : t_rst

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(irq, 0);
    chk(uvr, 0);
    t_regs();
    t_freeze();
    t_off();
    t_fall();
    t_rise();
    t_rst();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
